// file: roc_pkg.sv
package roc_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_PS      = 5000;
    localparam int MISS_TIME_US       = 100;
    localparam int MISS_CYCLES        = (MISS_TIME_US * 1000000) / CLK_PERIOD_PS;
    localparam int BLANK_TIME_MS      = 2;
    localparam int BLANK_CYCLES       = (BLANK_TIME_MS * 1000000) / (CLK_PERIOD_PS / 1000);
    localparam int STEP_TIME_US       = 1000;
    localparam int STEP_CYCLES        = (STEP_TIME_US * 1000000) / CLK_PERIOD_PS;

    // ------------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------------
    localparam int           CAP_W     = 4;
    localparam logic [3:0]   CAP_MIN   = 4'h0;
    localparam logic [3:0]   CAP_MAX   = 4'hF;
    localparam int           TIMER_W   = 32;
    localparam logic [1:0]   INC_XTAL  = 2'h1;
    localparam logic [1:0]   INC_LFO   = 2'h2;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_OFF  = 2'h0,
        ST_STEP = 2'h1,
        ST_DONE = 2'h3
    } roc_step_type;

    typedef struct packed {
        logic       crystal_mode_select;
        logic       gain_control_enable;
        logic       bias_double;
        logic       auto_step_enable;
        logic [3:0] load_cap_code;
        logic       osc_power_enable;
        logic       missing_clock_enable;
        logic       low_freq_osc_enable;
        logic       pin_short_control;
        logic       timer_run;
    } roc_ctrl_type;

    typedef struct packed {
        logic       analog_enable;
        logic       bias_double;
        logic       gain_control;
        logic       pin_short;
        logic [3:0] applied_cap;
    } roc_analog_type;

endpackage : roc_pkg

// file: roc_timer.sv
`timescale 1ns/1ps
module roc_timer
    import roc_pkg::*;
#(
    parameter int WIDTH = TIMER_W
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    // count request
    input  wire logic             tick_i,
    input  wire logic [1:0]       inc_i,
    // value
    output logic      [WIDTH-1:0] count_o
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [WIDTH-1:0] count;
    } roc_tmr_type;

    roc_tmr_type s_reg;
    roc_tmr_type s_next;

    // add one or two depending on source
    always_comb begin
        s_next = s_reg;
        if (tick_i) begin
            s_next.count = s_reg.count + WIDTH'(inc_i);
        end
    end

    // register the state
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign count_o = s_reg.count;

endmodule : roc_timer

// file: roc_osc_ctrl.sv
`timescale 1ns/1ps
// Behaviour
// - cmos clock: low bias, check failure later
// - self-oscillate runs at once, bias sets rate
// - low-frequency enable runs it at once, selects it once both sources are low
// - low-frequency source increments timer by two
// - four-bit cap code, monotonic sixteen settings
// - stepping climbs from smallest to programmed code
// - ready flag set when programmed code reached
// - bias double bit drives doubled bias
// - stuck oscillator over 100 us sets failure
// - failure routed out as event
// - clock-valid blanked 2 ms after power-on
module roc_osc_ctrl
    import roc_pkg::*;
#(
    parameter int MISS_CNT  = MISS_CYCLES,
    parameter int BLANK_CNT = BLANK_CYCLES,
    parameter int STEP_CNT  = STEP_CYCLES
) (
    // clock and reset
    input  wire logic                REF_CLK_I,
    input  wire logic                RST_N_I,
    // control bits
    input  wire roc_ctrl_type        CTRL_I,
    input  wire logic                FAIL_CLEAR_I,
    // oscillator inputs from pins and analog
    input  wire logic                XTAL_OSC_I,
    input  wire logic                LFO_OSC_I,
    input  wire logic                AMP_VALID_I,
    // analog settings
    output roc_analog_type           ANALOG_O,
    output logic                     LFO_ENABLE_O,
    // status
    output logic                     CLOCK_VALID_FLAG_O,
    output logic                     LOAD_CAP_READY_O,
    output logic                     OSC_FAIL_FLAG_O,
    output logic                     OSC_FAIL_EVENT_O,
    // timebase
    output logic                     TIMEBASE_TICK_O,
    output logic [TIMER_W-1:0]       TIMER_O
);

    localparam int MW = $clog2(MISS_CNT + 2);
    localparam int BW = $clog2(BLANK_CNT + 2);
    localparam int SW = $clog2(STEP_CNT + 2);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2:0]    xs;        // crystal input synchroniser
        logic [2:0]    ls;        // lfo input synchroniser
        logic [2:0]    vs;        // amplitude detect synchroniser
        logic          x_lvl;
        logic          l_lvl;
        logic          v_lvl;
        logic          sel_lfo;   // active source
        logic          sel_pend;  // switch waiting for safe point
        logic [MW-1:0] miss_cnt;
        logic          fail;
        logic          fail_evt;
        logic [BW-1:0] blank_cnt;
        roc_step_type  step;
        logic [SW-1:0] step_cnt;
        logic [3:0]    cap;
        logic          tick;
    } roc_state_type;

    roc_state_type s_reg;
    roc_state_type s_next;

    // input filter: accept once stages two and three agree
    function automatic logic filt(input logic [2:0] sh, input logic cur);
        filt = (sh[1] == sh[2]) ? sh[2] : cur;
    endfunction : filt

    logic [TIMER_W-1:0] timer_val;
    logic               x_new;
    logic               l_new;
    logic               src_new;
    logic               src_old;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        s_next          = s_reg;
        s_next.xs       = {s_reg.xs[1:0], XTAL_OSC_I};
        s_next.ls       = {s_reg.ls[1:0], LFO_OSC_I};
        s_next.vs       = {s_reg.vs[1:0], AMP_VALID_I};
        x_new           = filt(s_reg.xs, s_reg.x_lvl);
        l_new           = filt(s_reg.ls, s_reg.l_lvl);
        s_next.x_lvl    = x_new;
        s_next.l_lvl    = l_new;
        s_next.v_lvl    = filt(s_reg.vs, s_reg.v_lvl);
        s_next.fail_evt = 1'b0;
        s_next.tick     = 1'b0;

        // rising edge of the active source clocks the timer
        src_old = s_reg.sel_lfo ? s_reg.l_lvl : s_reg.x_lvl;
        src_new = s_reg.sel_lfo ? l_new : x_new;
        if (src_new && !src_old) begin
            s_next.tick = 1'b1;
        end

        // switch source only while both are low: no runt pulse
        if (CTRL_I.low_freq_osc_enable != s_reg.sel_lfo) begin
            s_next.sel_pend = 1'b1;
        end
        if (s_reg.sel_pend && !x_new && !l_new) begin
            s_next.sel_lfo  = CTRL_I.low_freq_osc_enable;
            s_next.sel_pend = 1'b0;
        end

        // missing-clock detector on the crystal oscillator level
        if (!CTRL_I.missing_clock_enable || (x_new != s_reg.x_lvl)) begin
            s_next.miss_cnt = '0;
        end else if (s_reg.miss_cnt <= MW'(MISS_CNT)) begin
            s_next.miss_cnt = s_reg.miss_cnt + MW'(1);
        end
        if (FAIL_CLEAR_I) begin
            s_next.fail = 1'b0;
        end
        // set wins over a clear in the same cycle
        if (CTRL_I.missing_clock_enable && s_reg.miss_cnt == MW'(MISS_CNT)) begin
            s_next.fail     = 1'b1;
            s_next.fail_evt = 1'b1;
        end

        // blanking window after oscillator power-on
        if (!CTRL_I.osc_power_enable) begin
            s_next.blank_cnt = '0;
        end else if (s_reg.blank_cnt < BW'(BLANK_CNT)) begin
            s_next.blank_cnt = s_reg.blank_cnt + BW'(1);
        end

        // load capacitance stepping
        unique case (s_reg.step)
            ST_OFF: begin
                s_next.cap = CAP_MIN;
                s_next.step_cnt = '0;
                if (CTRL_I.osc_power_enable) begin
                    if (CTRL_I.auto_step_enable) begin
                        s_next.step = ST_STEP;
                    end else begin
                        s_next.cap  = CTRL_I.load_cap_code;
                        s_next.step = ST_DONE;
                    end
                end
            end
            ST_STEP: begin
                if (s_reg.cap >= CTRL_I.load_cap_code) begin
                    s_next.cap  = CTRL_I.load_cap_code;
                    s_next.step = ST_DONE;
                end else if (s_reg.step_cnt == SW'(STEP_CNT - 1)) begin
                    s_next.cap      = s_reg.cap + 4'h1;
                    s_next.step_cnt = '0;
                end else begin
                    s_next.step_cnt = s_reg.step_cnt + SW'(1);
                end
            end
            ST_DONE: begin
                // later code falls apply at once; a rise restarts stepping while auto-step is enabled
                if (CTRL_I.load_cap_code > s_reg.cap && CTRL_I.auto_step_enable) begin
                    s_next.step = ST_STEP;
                end else begin
                    s_next.cap = CTRL_I.load_cap_code;
                end
            end
            default: s_next.step = ST_OFF;
        endcase
        if (!CTRL_I.osc_power_enable) begin
            s_next.step = ST_OFF;
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            s_reg      <= '0;
            s_reg.step <= ST_OFF;
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------------
    // timer
    // ------------------------------------------------------------------
    roc_timer #(
        .WIDTH (TIMER_W)
    ) u_timer (
        .clk_i   (REF_CLK_I),
        .rst_n_i (RST_N_I),
        .tick_i  (s_reg.tick && CTRL_I.timer_run),
        .inc_i   (s_reg.sel_lfo ? INC_LFO : INC_XTAL),
        .count_o (timer_val)
    );

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // gain control forced off outside crystal mode as a safety net
    assign ANALOG_O.analog_enable = CTRL_I.osc_power_enable;
    assign ANALOG_O.bias_double   = CTRL_I.bias_double;
    assign ANALOG_O.gain_control  = CTRL_I.gain_control_enable
                                    && CTRL_I.crystal_mode_select;
    assign ANALOG_O.pin_short     = CTRL_I.pin_short_control;
    assign ANALOG_O.applied_cap   = s_reg.cap;
    assign LFO_ENABLE_O           = CTRL_I.low_freq_osc_enable;

    // valid held low through blanking
    assign CLOCK_VALID_FLAG_O = s_reg.v_lvl && CTRL_I.osc_power_enable
                                && (s_reg.blank_cnt == BW'(BLANK_CNT));
    assign LOAD_CAP_READY_O   = (s_reg.step == ST_DONE)
                                && (s_reg.cap == CTRL_I.load_cap_code);
    assign OSC_FAIL_FLAG_O    = s_reg.fail;
    assign OSC_FAIL_EVENT_O   = s_reg.fail_evt;
    assign TIMEBASE_TICK_O    = s_reg.tick;
    assign TIMER_O            = timer_val;

endmodule : roc_osc_ctrl

// file: roc_osc_ctrl_checker.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// oscillator control checker
// ------------------------------------------------------------
module roc_osc_ctrl_checker
    import roc_pkg::*;
(
    // clock and reset
    input wire logic               REF_CLK_I,
    input wire logic               RST_N_I,
    // controls
    input wire roc_ctrl_type       CTRL_I,
    input wire logic               FAIL_CLEAR_I,
    // watched outputs
    input wire roc_analog_type     ANALOG_O,
    input wire logic               LOAD_CAP_READY_O,
    input wire logic               CLOCK_VALID_FLAG_O,
    input wire logic               OSC_FAIL_FLAG_O,
    input wire logic               OSC_FAIL_EVENT_O,
    input wire logic               TIMEBASE_TICK_O,
    input wire logic [TIMER_W-1:0] TIMER_O
);
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_N_I);
    // analog settings follow the controls at once
    a_bias_follow: assert property (ANALOG_O.bias_double == CTRL_I.bias_double)
        else $error("bias double not applied");
    a_gain_mode: assert property (ANALOG_O.gain_control ==
        (CTRL_I.gain_control_enable & CTRL_I.crystal_mode_select)) else $error("gain in wrong mode");
    // stepping climbs one code at a time; the 2-deep past skips the power-on restart
    a_cap_climb: assert property (CTRL_I.auto_step_enable && !LOAD_CAP_READY_O &&
        CTRL_I.osc_power_enable && $past(CTRL_I.osc_power_enable, 2) &&
        $changed(ANALOG_O.applied_cap) |-> ANALOG_O.applied_cap == $past(ANALOG_O.applied_cap) + 4'h1)
        else $error("cap step not by one");
    a_ready_cap: assert property (LOAD_CAP_READY_O |->
        ANALOG_O.applied_cap == CTRL_I.load_cap_code) else $error("ready before final code");
    a_valid_blank: assert property ($rose(CTRL_I.osc_power_enable) |->
        !CLOCK_VALID_FLAG_O [*8]) else $error("valid inside blanking");
    // failure flag: caused by the enabled detector, sticky, announced by an event
    a_fail_cause: assert property ($rose(OSC_FAIL_FLAG_O) |->
        $past(CTRL_I.missing_clock_enable)) else $error("fail without detector");
    a_fail_sticky: assert property (OSC_FAIL_FLAG_O && !FAIL_CLEAR_I |=> OSC_FAIL_FLAG_O)
        else $error("fail flag lost");
    a_fail_event: assert property ($rose(OSC_FAIL_FLAG_O) |-> OSC_FAIL_EVENT_O)
        else $error("no fail event");
    // timer moves only after a tick, by one or two
    a_tick_first: assert property ($changed(TIMER_O) |-> $past(TIMEBASE_TICK_O))
        else $error("timer moved without tick");
    a_timer_inc: assert property (TIMEBASE_TICK_O && CTRL_I.timer_run |=>
        (TIMER_O - $past(TIMER_O)) inside {32'h1, 32'h2}) else $error("bad timer step");
    c_ready: cover property ($rose(LOAD_CAP_READY_O));
    c_fail: cover property (OSC_FAIL_EVENT_O);
    c_tick: cover property (TIMEBASE_TICK_O && CTRL_I.timer_run);
endmodule : roc_osc_ctrl_checker

bind roc_osc_ctrl roc_osc_ctrl_checker u_chk (.REF_CLK_I, .RST_N_I, .CTRL_I, .FAIL_CLEAR_I,
    .ANALOG_O, .LOAD_CAP_READY_O, .CLOCK_VALID_FLAG_O, .OSC_FAIL_FLAG_O, .OSC_FAIL_EVENT_O,
    .TIMEBASE_TICK_O, .TIMER_O);

// file: roc_xtal_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// crystal or cmos clock source on the crystal input pin
// ------------------------------------------------------------
module roc_xtal_model #(
    parameter int HALF_NS = 40
) (
    // run request and pin level
    input  wire logic run_i,
    output logic      osc_o
);
    // a stopped source freezes at its last level, the case the detector must catch
    initial osc_o = 1'b0;
    always #(HALF_NS) if (run_i) osc_o = ~osc_o;
endmodule : roc_xtal_model

// file: roc_osc_ctrl_test.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// oscillator control testbench
// ------------------------------------------------------------
module roc_osc_ctrl_test;
    import roc_pkg::*;
    logic               clk, rst_n, clr, run, lfo, amp, xosc;
    logic               lfo_en, vld, rdy, fail, fev, tick;
    roc_ctrl_type       ctrl;
    roc_analog_type     ana;
    logic [TIMER_W-1:0] tmr, t0;
    int                 num_errors, checks_done, waited;
    roc_xtal_model #(.HALF_NS(40)) u_xtal (.run_i(run), .osc_o(xosc));
    // short counts keep the run small
    roc_osc_ctrl #(.MISS_CNT(20), .BLANK_CNT(30), .STEP_CNT(4)) dut (
        .REF_CLK_I(clk),
        .RST_N_I(rst_n),
        .CTRL_I(ctrl),
        .FAIL_CLEAR_I(clr),
        .XTAL_OSC_I(xosc),
        .LFO_OSC_I(lfo),
        .AMP_VALID_I(amp),
        .ANALOG_O(ana),
        .LFO_ENABLE_O(lfo_en),
        .CLOCK_VALID_FLAG_O(vld),
        .LOAD_CAP_READY_O(rdy),
        .OSC_FAIL_FLAG_O(fail),
        .OSC_FAIL_EVENT_O(fev),
        .TIMEBASE_TICK_O(tick),
        .TIMER_O(tmr)
    );
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // internal low-frequency source, still while disabled
    always #50 lfo = ctrl.low_freq_osc_enable ? ~lfo : 1'b0;
    task tk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tk
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task results;
        if (num_errors == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : results
    function logic cond(input int w);
        case (w)
            0: return tick;
            1: return rdy;
            default: return fail;
        endcase
    endfunction : cond
    // bounded wait; running out counts as a mismatch
    task wait_on(input int w, input int lim);
        waited = 0;
        while (cond(w) !== 1'b1) begin
            if (waited == lim) begin
                num_errors++;
                results;
            end
            tk(1);
            waited++;
        end
    endtask : wait_on
    task tick_inc(input logic [31:0] inc);
        wait_on(0, 100);
        t0 = tmr;
        tk(1);
        check(tmr - t0, inc);
    endtask : tick_inc
    // restart with a new code; power drops first so stepping begins afresh
    task step_to(input logic [3:0] code);
        ctrl.osc_power_enable = 1'b0;
        tk(2);
        check(ana.analog_enable, 1'b0);
        ctrl.load_cap_code = code;
        ctrl.osc_power_enable = 1'b1;
        tk(1);
        check(ana.analog_enable, 1'b1);
        check(vld, 1'b0);
        wait_on(1, 100);
        check(ana.applied_cap, code);
    endtask : step_to
    initial begin
        ctrl = '0;
        clr = 1'b0;
        run = 1'b1;
        amp = 1'b1;
        lfo = 1'b0;
        rst_n = 1'b0;
        num_errors = 0;
        checks_done = 0;
        tk(5);
        rst_n = 1'b1;
        tk(1);
        // crystal startup with doubled bias and no gain control
        ctrl.crystal_mode_select = 1'b1;
        ctrl.bias_double = 1'b1;
        ctrl.auto_step_enable = 1'b1;
        tk(1);
        check(ana.bias_double, 1'b1);
        check(ana.gain_control, 1'b0);
        step_to(4'h5);
        step_to(CAP_MIN);
        step_to(CAP_MAX);
        tk(40);
        check(vld, 1'b1);
        // amplitude loss drops valid after the three-stage filter
        amp = 1'b0;
        tk(4);
        check(vld, 1'b0);
        amp = 1'b1;
        tk(4);
        check(vld, 1'b1);
        ctrl.gain_control_enable = 1'b1;
        ctrl.bias_double = 1'b0;
        tk(1);
        check(ana.gain_control, 1'b1);
        check(ana.bias_double, 1'b0);
        ctrl.timer_run = 1'b1;
        tick_inc(32'h1);
        // stuck source; the stop may land up to a half period after the last edge
        ctrl.missing_clock_enable = 1'b1;
        tk(10);
        check(fail, 1'b0);
        run = 1'b0;
        wait_on(2, 60);
        check(waited >= 10, 1'b1);
        check(fev, 1'b1);
        run = 1'b1;
        ctrl.missing_clock_enable = 1'b0;
        clr = 1'b1;
        tk(1);
        clr = 1'b0;
        tk(1);
        check(fail, 1'b0);
        // self-oscillate, then the low-frequency source and back
        ctrl.gain_control_enable = 1'b0;
        ctrl.crystal_mode_select = 1'b0;
        ctrl.pin_short_control = 1'b1;
        tk(1);
        check(ana.gain_control, 1'b0);
        check(ana.pin_short, 1'b1);
        tick_inc(32'h1);
        ctrl.low_freq_osc_enable = 1'b1;
        tk(1);
        check(lfo_en, 1'b1);
        tk(40);
        tick_inc(32'h2);
        tick_inc(32'h2);
        ctrl.low_freq_osc_enable = 1'b0;
        tk(40);
        tick_inc(32'h1);
        results;
    end
endmodule : roc_osc_ctrl_test
